// ===== src/mwir_cfg.svh
`ifndef MWIR_CFG_SVH
`define MWIR_CFG_SVH

`define MWIR_WR_DW      8
`define MWIR_RD_DW      64
`define MWIR_WR_AW      6
`define MWIR_RD_AW      4
`define MWIR_MAX_RATIO  4
`define MWIR_BUF_DEPTH  2
`define MWIR_RD_LATENCY 2

`endif

// ===== src/mwir_pkg.sv
`include "mwir_cfg.svh"

package mwir_pkg;

  typedef struct packed {
    logic [`MWIR_WR_AW-1:0] addr;
    logic [`MWIR_WR_DW-1:0] data;
  } mwir_wr_t;

  typedef enum logic [1:0] {
    MWIR_EMPTY = 2'h0,
    MWIR_ONE   = 2'h1,
    MWIR_TWO   = 2'h3
  } mwir_occ_t;

endpackage

// ===== src/mwir_bank.sv
`timescale 1ns/100ps
`include "mwir_cfg.svh"

module mwir_bank import mwir_pkg::*; #(
  parameter int WR_DW = `MWIR_WR_DW,
  parameter int Q_DW  = `MWIR_RD_DW / 2,
  parameter int WR_AW = `MWIR_WR_AW,
  parameter int RD_AW = `MWIR_RD_AW
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             wrEn,
  input  wire logic [WR_AW-1:0] wrAddr,
  input  wire logic [WR_DW-1:0] wrData,
  input  wire logic             rdEn,
  input  wire logic [RD_AW-1:0] rdAddr,
  output logic      [Q_DW-1:0]  rdData
);

  localparam int LANES = Q_DW / WR_DW;
  localparam int LW    = (LANES > 1) ? $clog2(LANES) : 1;
  localparam int ROWS  = (2 ** (WR_AW - 1)) / LANES;
  localparam int RW    = (ROWS > 1) ? $clog2(ROWS) : 1;

  if (!(LANES == 1 || LANES == 2 || LANES == `MWIR_MAX_RATIO) ||
      Q_DW != LANES * WR_DW) begin : g_bad_ratio
    $error("Bank width ratio must be 1, 1/2 or 1/4.");
  end

  logic [Q_DW-1:0]  mem [ROWS];
  logic [Q_DW-1:0]  rdData_d;
  logic [WR_AW-2:0] localIdx;
  logic [RW-1:0]    wrRow;
  logic [RW-1:0]    rdRow;

  // The address bit that picked this bank is dropped; the rest is local.
  assign localIdx = wrAddr[WR_AW-1:1];
  assign wrRow    = RW'(localIdx >> LW);
  assign rdRow    = rdAddr[RW-1:0];

  // Writes land in one byte lane of one row on the shared clock.
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrRow][(LANES > 1 ? int'(localIdx) % LANES : 0) * WR_DW +: WR_DW]
        <= wrData;
    end
  end

  // Reads return the stored row only; no write data is forwarded.
  always_comb begin
    rdData_d = rdData;
    if (rdEn) begin
      rdData_d = mem[rdRow];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= '0;
    end else begin
      rdData <= rdData_d;
    end
  end

  AST_OLD_DATA_ON_READ: assert property (@(posedge clk) disable iff (!resetn)
    rdEn |=> rdData == $past(mem[rdRow]))
    else $error("Bank read did not return the stored row.");

endmodule // mwir_bank

// ===== src/mwir_top.sv
`timescale 1ns/100ps
`include "mwir_cfg.svh"

module mwir_top import mwir_pkg::*; #(
  parameter int WR_DW = `MWIR_WR_DW,
  parameter int RD_DW = `MWIR_RD_DW,
  parameter int WR_AW = `MWIR_WR_AW,
  parameter int RD_AW = `MWIR_RD_AW
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             wrReq,
  input  wire mwir_wr_t         wrCmd,
  input  wire logic             rdReq,
  input  wire logic [RD_AW-1:0] rdAddr,
  output logic                  rdReady,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [RD_DW-1:0] outData
);

  localparam int HALF_DW = RD_DW / 2;
  localparam int SLICES  = RD_DW / (2 * WR_DW);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  if (WR_DW != `MWIR_WR_DW || WR_AW != `MWIR_WR_AW) begin : g_bad_wr
    $error("Write port width must match the write command struct.");
  end
  if (RD_DW != 8 * WR_DW) begin : g_bad_total
    $error("Read width must be eight times the write width.");
  end
  if (RD_AW < WR_AW - 3) begin : g_bad_rdaw
    $error("Read address too narrow to reach every word.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write steering.

  function automatic logic [1:0] bankEnables(input logic req,
                                             input logic lsb);
    bankEnables = {req & lsb, req & ~lsb};
  endfunction

  logic [1:0] wrEnBank;
  assign wrEnBank = bankEnables(wrReq, wrCmd.addr[0]);

  ////////////////////////////////////////////////////////////////////////////
  // Read issue and the two banks.

  logic               rdAccept;
  logic               inFlight_q;
  logic               inFlight_d;
  logic [HALF_DW-1:0] qBankA;
  logic [HALF_DW-1:0] qBankB;

  // A read is taken only when the buffer is sure to have room for it.
  assign rdAccept = rdReq & rdReady;

  always_comb begin
    inFlight_d = rdAccept;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inFlight_q <= 1'b0;
    end else begin
      inFlight_q <= inFlight_d;
    end
  end

  // Two 1/4 banks together give the 1/8 ratio.
  mwir_bank #(
    .WR_DW (WR_DW),
    .Q_DW  (HALF_DW),
    .WR_AW (WR_AW),
    .RD_AW (RD_AW)
  ) bankA (
    .clk    (clk),
    .resetn (resetn),
    .wrEn   (wrEnBank[0]),
    .wrAddr (wrCmd.addr),
    .wrData (wrCmd.data),
    .rdEn   (rdAccept),
    .rdAddr (rdAddr),
    .rdData (qBankA)
  );

  mwir_bank #(
    .WR_DW (WR_DW),
    .Q_DW  (HALF_DW),
    .WR_AW (WR_AW),
    .RD_AW (RD_AW)
  ) bankB (
    .clk    (clk),
    .resetn (resetn),
    .wrEn   (wrEnBank[1]),
    .wrAddr (wrCmd.addr),
    .wrData (wrCmd.data),
    .rdEn   (rdAccept),
    .rdAddr (rdAddr),
    .rdData (qBankB)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Rebuild the wide word from the registered bank outputs.

  logic [RD_DW-1:0] rebuilt_read_word;

  for (genvar k = 0; k < SLICES; k++) begin : g_rebuild
    assign rebuilt_read_word[2*k*WR_DW +: WR_DW]     =
      qBankA[k*WR_DW +: WR_DW];
    assign rebuilt_read_word[(2*k+1)*WR_DW +: WR_DW] =
      qBankB[k*WR_DW +: WR_DW];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; the head register drives the output directly.

  mwir_occ_t        occ_q;
  mwir_occ_t        occ_d;
  logic [RD_DW-1:0] head_q;
  logic [RD_DW-1:0] head_d;
  logic [RD_DW-1:0] tail_q;
  logic [RD_DW-1:0] tail_d;
  logic             ready_q;
  logic             ready_d;
  logic             valid_q;
  logic             valid_d;
  logic             push;
  logic             pop;

  assign push = inFlight_q;
  assign pop  = outValid & outReady;

  always_comb begin
    occ_d  = occ_q;
    head_d = head_q;
    tail_d = tail_q;
    case (occ_q)
      MWIR_EMPTY: begin
        if (push) begin
          head_d = rebuilt_read_word;
          occ_d  = MWIR_ONE;
        end
      end
      MWIR_ONE: begin
        if (push && pop) begin
          head_d = rebuilt_read_word;
        end else if (push) begin
          tail_d = rebuilt_read_word;
          occ_d  = MWIR_TWO;
        end else if (pop) begin
          occ_d  = MWIR_EMPTY;
        end
      end
      MWIR_TWO: begin
        if (pop) begin
          head_d = tail_q;
          if (push) begin
            tail_d = rebuilt_read_word;
          end else begin
            occ_d  = MWIR_ONE;
          end
        end
      end
      default: begin
        occ_d = MWIR_EMPTY;
      end
    endcase
    // Room is counted with the read being accepted into the banks this cycle.
    case (occ_d)
      MWIR_EMPTY: ready_d = 1'b1;
      MWIR_ONE:   ready_d = ~inFlight_d;
      default:    ready_d = 1'b0;
    endcase
    valid_d = (occ_d != MWIR_EMPTY);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      occ_q   <= MWIR_EMPTY;
      head_q  <= '0;
      tail_q  <= '0;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      occ_q   <= occ_d;
      head_q  <= head_d;
      tail_q  <= tail_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
  end

  assign rdReady  = ready_q;
  assign outValid = valid_q;
  assign outData  = head_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence sAccepted;
    rdReq && rdReady;
  endsequence

  sequence sDelivered;
    ##2 outValid;
  endsequence

  AST_WR_EVEN_TO_A: assert property (@(posedge clk) disable iff (!resetn)
    wrReq && !wrCmd.addr[0] |-> wrEnBank == 2'h1)
    else $error("Even write address did not select bank A only.");

  AST_WR_ODD_TO_B: assert property (@(posedge clk) disable iff (!resetn)
    wrReq && wrCmd.addr[0] |-> wrEnBank == 2'h2)
    else $error("Odd write address did not select bank B only.");

  AST_NO_WR_IDLE: assert property (@(posedge clk) disable iff (!resetn)
    !wrReq |-> wrEnBank == 2'h0)
    else $error("Bank written without a write request.");

  AST_READ_LATENCY: assert property (@(posedge clk) disable iff (!resetn)
    sAccepted |-> sDelivered)
    else $error("Accepted read not visible two cycles later.");

  AST_REBUILD_ORDER: assert property (@(posedge clk) disable iff (!resetn)
    occ_q == MWIR_EMPTY && inFlight_q |=>
      outData[2*WR_DW-1:0] == {$past(qBankB[WR_DW-1:0]),
                               $past(qBankA[WR_DW-1:0])})
    else $error("Lowest slice not rebuilt as bank A then bank B.");

  AST_REBUILD_TOP: assert property (@(posedge clk) disable iff (!resetn)
    occ_q == MWIR_EMPTY && inFlight_q |=>
      outData[RD_DW-1 -: WR_DW] == $past(qBankB[HALF_DW-1 -: WR_DW]))
    else $error("Top byte of rebuilt word not from bank B.");

  AST_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!resetn)
    occ_q == MWIR_TWO && !pop |-> !push)
    else $error("Read arrived at a full output buffer.");

  AST_STALL_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
    outValid && !outReady |=> outValid && $stable(outData))
    else $error("Stalled output word changed or vanished.");

endmodule // mwir_top

// ===== verif/mwir_user_model.sv
`timescale 1ns/100ps
module mwir_user_model import mwir_pkg::*; (
  input  wire logic        clk,
  output logic             wrReq,
  output mwir_wr_t         wrCmd,
  output logic             rdReq,
  output logic [3:0]       rdAddr,
  output logic             outReady,
  input  wire logic        rdReady,
  input  wire logic        outValid,
  input  wire logic [63:0] outData
);
////////////////////////////////////////
  int timeouts = 0;

  initial begin
    wrReq = 1'h0;
    wrCmd = '0;
    rdReq = 1'h0;
    rdAddr = 4'h0;
    outReady = 1'h0;
  end

  task automatic putByte(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    wrReq = 1'h1;
    wrCmd = '{addr: a, data: d};
    @(posedge clk);
  endtask

  // Released write lines show the inverse of the last value.
  task automatic idleWrite();
    @(negedge clk);
    wrReq = 1'h0;
    wrCmd = ~wrCmd;
  endtask

  // Issues reads back to back while refusing every word.
  task automatic burst(input logic [3:0] a, output int acc);
    acc = 0;
    @(negedge clk);
    outReady = 1'h0;
    rdReq = 1'h1;
    rdAddr = a;
    repeat (6) begin
      @(posedge clk);
      if (rdReady === 1'h1) acc++;
      @(negedge clk);
      rdAddr = a + 4'(acc);
    end
    rdReq = 1'h0;
  endtask

  // Takes one word; lat counts rising edges up to the handshake.
  task automatic drain(output logic [63:0] w, output int lat);
    outReady = 1'h1;
    for (lat = 1; lat <= 20; lat++) begin
      @(posedge clk);
      if (outValid === 1'h1) break;
    end
    if (lat > 20) timeouts++;
    w = outData;
    @(negedge clk);
  endtask

  task automatic getWord(input logic [3:0] a, input int stall,
                         output logic [63:0] w, output int lat);
    int n;
    @(negedge clk);
    rdReq = 1'h1;
    rdAddr = a;
    outReady = 1'h0;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (rdReady === 1'h1) break;
    end
    if (n == 20) timeouts++;
    @(negedge clk);
    rdReq = 1'h0;
    rdAddr = ~a;
    repeat (stall) @(negedge clk);
    drain(w, lat);
  endtask
endmodule // mwir_user_model

// ===== verif/mwir_tb_top.sv
`timescale 1ns/100ps
module mwir_tb_top import mwir_pkg::*;;
  logic        clk = 1'h0;
  logic        resetn = 1'h0;
  logic        wrReq;
  mwir_wr_t    wrCmd;
  logic        rdReq;
  logic [3:0]  rdAddr;
  logic        rdReady;
  logic        outValid;
  logic        outReady;
  logic [63:0] outData;
  logic [7:0]  mem [64];
  logic [63:0] w;
  int          lat;
  int          acc;
  int          miscompares = 0;
  int          checks = 0;
////////////////////////////////////////
  always #4 clk = ~clk;

  mwir_top mwir_top_inst (.clk(clk), .resetn(resetn), .wrReq(wrReq),
    .wrCmd(wrCmd), .rdReq(rdReq), .rdAddr(rdAddr), .rdReady(rdReady),
    .outValid(outValid), .outReady(outReady), .outData(outData));

  mwir_user_model mwir_user_model_inst (.clk(clk), .wrReq(wrReq),
    .wrCmd(wrCmd), .rdReq(rdReq), .rdAddr(rdAddr), .outReady(outReady),
    .rdReady(rdReady), .outValid(outValid), .outData(outData));

  task automatic check(input string what, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Byte n of the memory sits in lane n%8 of word n/8.
  function automatic logic [63:0] expWord(input int k);
    for (int i = 0; i < 8; i++) expWord[8*i +: 8] = mem[8*(k%8)+i];
  endfunction

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic fillAndRead();
    for (int n = 0; n < 64; n++) begin
      mem[n] = 8'(n * 7) ^ 8'h3c;
      mwir_user_model_inst.putByte(6'(n), mem[n]);
    end
    mwir_user_model_inst.idleWrite();
    for (int k = 0; k < 9; k++) begin
      mwir_user_model_inst.getWord(4'(k), 0, w, lat);
      check("word", w, expWord(k));
      check("latency", 64'(lat), 64'h2);
    end
  endtask

  task automatic stallRead();
    mwir_user_model_inst.getWord(4'h5, 6, w, lat);
    check("stalled word", w, expWord(5));
  endtask

  task automatic bufferFull();
    mwir_user_model_inst.burst(4'h2, acc);
    check("accepted", 64'(acc), 64'h2);
    for (int k = 2; k < 4; k++) begin
      mwir_user_model_inst.drain(w, lat);
      check("queued word", w, expWord(k));
    end
  endtask

  task automatic readDuringWrite();
    fork
      begin
        mwir_user_model_inst.putByte(6'h09, 8'hc3);
        mwir_user_model_inst.idleWrite();
      end
      mwir_user_model_inst.getWord(4'h1, 0, w, lat);
    join
    check("old data", w, expWord(1));
    mem[9] = 8'hc3;
    mwir_user_model_inst.getWord(4'h1, 0, w, lat);
    check("new data", w, expWord(1));
  endtask

  task automatic resetMid();
    mwir_user_model_inst.burst(4'h4, acc);
    check("accepted before reset", 64'(acc), 64'h2);
    resetn = 1'h0;
    #1;
    check("ready in reset", 64'(rdReady), 64'h0);
    check("valid in reset", 64'(outValid), 64'h0);
    check("data in reset", outData, 64'h0);
    repeat (2) @(negedge clk);
    resetn = 1'h1;
    @(negedge clk);
    check("ready after reset", 64'(rdReady), 64'h1);
    mwir_user_model_inst.getWord(4'h4, 0, w, lat);
    check("word after reset", w, expWord(4));
  endtask

  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (4) @(negedge clk);
    resetn = 1'h1;
    fillAndRead();
    stallRead();
    bufferFull();
    readDuringWrite();
    resetMid();
    check("timeouts", 64'(mwir_user_model_inst.timeouts), 64'h0);
    end_of_test();
  end
endmodule // mwir_tb_top
